// ### src/cbd_pkg.sv
// package for the carrier local bus decoder: address map, types, states
package cbd_pkg;
  // io window offsets (byte addresses from the host-assigned base)
  localparam logic [7:0] IO_LINK_WORD = 8'h10;
  localparam logic [7:0] IO_CTRL_STAT = 8'h14;
  localparam logic [7:0] IO_INT_SETUP = 8'h18;
  localparam logic [7:0] IO_ROUTE_LO = 8'h20;
  localparam logic [7:0] IO_ROUTE_HI = 8'h3F;
  localparam logic [7:0] IO_ROUTE_GAP = 8'h24; // unassigned inside the window
  localparam logic [7:0] IO_INT_WORD = 8'h40;
  localparam logic [7:0] IO_SCAN_LO = 8'h80;
  localparam logic [7:0] IO_SCAN_HI = 8'hAF;
  // host memory window
  localparam logic [31:0] MEM_SRAM_LO = 32'h0000_0000;
  localparam logic [31:0] MEM_SRAM_HI = 32'h000F_FFFF;
  localparam logic [31:0] MEM_GBUS_LO = 32'h0020_0000;
  localparam logic [31:0] MEM_GBUS_HI = 32'h0020_007F;
  localparam logic [31:0] MEM_LINK_ALIAS = 32'h0020_0090;
  localparam logic [31:0] MEM_CS_ALIAS = 32'h0020_0094;
  localparam logic [31:0] MEM_INT_ALIAS = 32'h0020_0098;
  localparam logic [31:0] MEM_PDATA_LO = 32'h0020_0240;
  localparam logic [31:0] MEM_PDATA_HI = 32'h0020_025F;
  localparam logic [31:0] MEM_PCTRL_LO = 32'h0020_0260;
  localparam logic [31:0] MEM_PCTRL_HI = 32'h0020_027F;
  // master module window
  localparam logic [31:0] MOD_SRAM_LO = 32'hD000_0000;
  localparam logic [31:0] MOD_SRAM_HI = 32'hD00F_FFFF;
  localparam logic [31:0] MOD_BREG_LO = 32'h1C00_0000;
  localparam logic [31:0] MOD_BREG_HI = 32'h1C00_00FF;
  localparam logic [31:0] MOD_APER_LO = 32'h1800_0000;
  localparam logic [31:0] MOD_APER_HI = 32'h183F_FFFF;
  // dma view of sram: local address line 28 high
  localparam int DMA_ADDR_BIT = 28;
  // that line counts words, so skip the byte-lane bits to reach it
  localparam int BYTE_LANE_W = 2;
  localparam logic [31:0] DMA_SRAM_LO = 32'h4000_0000;
  localparam logic [31:0] DMA_SRAM_HI = 32'h400F_FFFF;
  // global bus select pattern seen by the module
  localparam int GA_BIT30 = 30;
  localparam int GA_BIT19 = 19;
  localparam int GA_BIT7 = 7;
  localparam int GA_BIT5 = 5;
  localparam logic [31:0] GBUS_HIGH_BITS = 32'h4008_0000;
  // field widths and reset values
  localparam int ROUTE_W = 8;
  localparam int IWORD_W = 16;
  localparam int SCAN_W = 16;
  localparam int SRAM_AW = 20;
  localparam logic [7:0] ROUTE_RST = 8'h2C;
  localparam logic [15:0] IWORD_RST = 16'h0000;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  // bus timing, kept for reference only; neither the arbiter nor the decode uses them
  localparam real LBUS_MHZ = 33.0;
  localparam real MIN_STROBE_NS = 20.0;

  // destination of a decoded access
  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_SRAM = 4'h1,
    TGT_LINK = 4'h2,
    TGT_CTST = 4'h3,
    TGT_INTS = 4'h4,
    TGT_ROUTE = 4'h5,
    TGT_IWORD = 4'h6,
    TGT_SCAN = 4'h7,
    TGT_GBUS = 4'h8,
    TGT_PDATA = 4'h9,
    TGT_PCTRL = 4'hA,
    TGT_BREG = 4'hB,
    TGT_APER = 4'hC
  } cbd_tgt_t;

  // arbiter ownership state
  typedef enum logic [1:0] {
    OWN_IDLE = 2'b00,
    OWN_MOD = 2'b01,
    OWN_BRG = 2'b10
  } cbd_own_t;

  // one local bus request
  typedef struct packed {
    logic req;
    logic write;
    logic io;
    logic dma;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cbd_req_t;

  // strobe towards one downstream resource
  typedef struct packed {
    logic sel;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cbd_strb_t;
endpackage

// ### src/cbd_local_bus_decoder.sv
// carrier local bus decoder: arbiter, address decode and local registers
`timescale 1ns/1ps
// Notes on behaviour
// - io registers sit at fixed offsets added to the host-assigned base
// - io 0x10 write sends outgoing link word, read returns incoming word
// - io 0x14 write goes to control, read returns status
// - io 0x20..0x3F, except 0x24, is the readable, writable link routing register
// - io 0x40 is a 16-bit interrupt word, writable and readable
// - io 0x80..0xAF forwarded to scan-bus controller as 16-bit accesses
// - host memory 0x0..0xFFFFF maps the 1MB shared sram
// - memory 0x00200090 aliases the link word port exactly
// - memory 0x00200094 aliases control on write, status on read
// - memory 0x00200098 aliases the write-only interrupt setup register
// - global bus window passed to module with address bits 30,19 high
// - 0x00200240..0x0020025F is the parallel link data register
// - 0x00200260..0x0020027F is the parallel link control and status
// - master module sees shared sram at 0xD0000000..0xD00FFFFF
// - master module reaches bridge registers at 0x1C000000..0x1C0000FF
// - module 0x18000000..0x183FFFFF routes to bridge aperture zero
// - bridge dma sees sram at 0x40000000, address line 28 high
// - arbiter grants the local bus to at most one requester at a time
// - all transfers on one 33MHz clock, also offered to module site
// - bridge buffers dsp transfers in 256 by 32-bit fifos
module cbd_local_bus_decoder
  import cbd_pkg::*;
(
  input wire logic clk, // local bus clock
  input wire logic nrst, // async reset, active low
  input wire cbd_req_t modReq, // master module request
  output logic modStall, // module must hold its request
  output logic modRdValid, // read data valid for module
  input wire cbd_req_t brgReq, // bridge (host or dma) request
  output logic brgStall, // bridge must hold its request
  output logic brgRdValid, // read data valid for bridge
  output logic [31:0] rdData, // registered read data
  output logic modGrant, // module owns the bus
  output logic brgGrant, // bridge owns the bus
  output logic siteClockOut, // clock offered to the module site
  output cbd_strb_t sramStrb, // shared sram strobe
  input wire logic [31:0] sramRdata, // sram read data
  output cbd_strb_t linkStrb, // link word port strobe
  input wire logic [31:0] linkInWord, // incoming link word
  output cbd_strb_t ctrlStrb, // control write strobe
  input wire logic [31:0] statusWord, // status value
  output cbd_strb_t intSetupStrb, // interrupt setup write strobe
  output logic [7:0] linkRouting, // routing configuration register
  output logic [15:0] interruptWord, // interrupt word register
  output cbd_strb_t scanStrb, // scan-bus controller strobe
  input wire logic [15:0] scanRdata, // scan-bus controller read data
  output cbd_strb_t gbusStrb, // module global bus strobe
  input wire logic [31:0] gbusRdata, // global bus read data
  output cbd_strb_t pdataStrb, // parallel link data strobe
  output cbd_strb_t pctrlStrb, // parallel link ctrl/stat strobe
  input wire logic [15:0] pdataRdata, // parallel link data read
  input wire logic [15:0] pctrlRdata, // parallel link status read
  output cbd_strb_t bregStrb, // bridge internal register strobe
  output cbd_strb_t aperStrb, // bridge aperture zero strobe
  input wire logic [31:0] brgRdata // bridge register/aperture data
);

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  cbd_own_t own_q, own_d;

  // a single owner register makes two grants at once impossible
  always_comb begin
    own_d = own_q;
    case (own_q)
      OWN_IDLE: begin
        if (brgReq.req) own_d = OWN_BRG;
        else if (modReq.req) own_d = OWN_MOD;
      end
      OWN_MOD: begin
        if (!modReq.req) own_d = brgReq.req ? OWN_BRG : OWN_IDLE;
      end
      OWN_BRG: begin
        if (!brgReq.req) own_d = modReq.req ? OWN_MOD : OWN_IDLE;
      end
      default: own_d = OWN_IDLE;
    endcase
  end

  // ownership lasts while the owner keeps its request up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) own_q <= OWN_IDLE;
    else own_q <= own_d;
  end

  assign modGrant = (own_q == OWN_MOD);
  assign brgGrant = (own_q == OWN_BRG);
  // loser holds its request until the bus is its own
  assign modStall = modReq.req && !modGrant;
  assign brgStall = brgReq.req && !brgGrant;
  // the site is offered the very bus clock, avoiding its own oscillator
  assign siteClockOut = clk;

  ////////////////////////////////////////////////////////////////////////////
  // address decode of the granted request
  cbd_req_t cur;
  assign cur = modGrant ? modReq : brgReq;
  wire logic live = (modGrant && modReq.req) || (brgGrant && brgReq.req);
  wire logic [31:0] a = cur.addr;
  wire logic [7:0] ioOff = a[7:0]; // offset from host base
  wire logic [31:0] aWord = {a[31:2], 2'b00};
  // global bus select as the module sees it
  wire logic gaMatch = a[GA_BIT30] && a[GA_BIT19] && !a[GA_BIT7] &&
                       !a[GA_BIT5];
  cbd_tgt_t tgt;

  // io space first, then bridge memory space, then module space
  always_comb begin
    tgt = TGT_NONE;
    if (!live) tgt = TGT_NONE;
    else if (!modGrant && cur.io) begin
      if (ioOff == IO_LINK_WORD) tgt = TGT_LINK;
      else if (ioOff == IO_CTRL_STAT) tgt = TGT_CTST;
      else if (ioOff == IO_INT_SETUP) tgt = TGT_INTS;
      else if (ioOff >= IO_ROUTE_LO && ioOff <= IO_ROUTE_HI &&
               ioOff != IO_ROUTE_GAP)
        tgt = TGT_ROUTE;
      else if (ioOff == IO_INT_WORD) tgt = TGT_IWORD;
      else if (ioOff >= IO_SCAN_LO && ioOff <= IO_SCAN_HI)
        tgt = TGT_SCAN;
      else tgt = TGT_NONE;
    end else if (!modGrant && cur.dma) begin
      if (a >= DMA_SRAM_LO && a <= DMA_SRAM_HI &&
          a[DMA_ADDR_BIT + BYTE_LANE_W])
        tgt = TGT_SRAM;
    end else if (!modGrant) begin
      if (a <= MEM_SRAM_HI) tgt = TGT_SRAM;
      else if (aWord == MEM_LINK_ALIAS) tgt = TGT_LINK;
      else if (aWord == MEM_CS_ALIAS) tgt = TGT_CTST;
      else if (aWord == MEM_INT_ALIAS) tgt = TGT_INTS;
      else if (a >= MEM_GBUS_LO && a <= MEM_GBUS_HI) tgt = TGT_GBUS;
      else if (a >= MEM_PDATA_LO && a <= MEM_PDATA_HI)
        tgt = TGT_PDATA;
      else if (a >= MEM_PCTRL_LO && a <= MEM_PCTRL_HI)
        tgt = TGT_PCTRL;
    end else begin
      if (a >= MOD_SRAM_LO && a <= MOD_SRAM_HI) tgt = TGT_SRAM;
      else if (a >= MOD_BREG_LO && a <= MOD_BREG_HI) tgt = TGT_BREG;
      else if (a >= MOD_APER_LO && a <= MOD_APER_HI) tgt = TGT_APER;
      else if (gaMatch) tgt = TGT_GBUS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // downstream strobes; sram sees only its 20-bit byte offset
  wire logic [31:0] sramOff = {{(32 - SRAM_AW){1'b0}}, a[SRAM_AW-1:0]};
  // global bus address carries the select bits the module decodes
  wire logic [31:0] gbusAddr = a | (modGrant ? ZERO32 : GBUS_HIGH_BITS);

  // write flag and data go in as arguments, so every strobe follows them
  wire logic wr = cur.write;
  wire logic [31:0] wd = cur.wdata;
  wire logic [31:0] wd16 = {16'h0000, cur.wdata[15:0]};

  function automatic cbd_strb_t mkStrb(input logic s, input logic wIn,
    input logic [31:0] ad, input logic [31:0] dIn);
    mkStrb.sel = s;
    mkStrb.write = s && wIn;
    mkStrb.addr = ad;
    mkStrb.wdata = dIn;
  endfunction

  assign sramStrb = mkStrb(tgt == TGT_SRAM, wr, sramOff, wd);
  assign linkStrb = mkStrb(tgt == TGT_LINK, wr, a, wd);
  // control is write only; reads of 0x14 never pulse it
  assign ctrlStrb = mkStrb((tgt == TGT_CTST) && wr, wr, a, wd);
  assign intSetupStrb = mkStrb((tgt == TGT_INTS) && wr, wr, a, wd);
  // scan controller takes 16-bit data only
  assign scanStrb = mkStrb(tgt == TGT_SCAN, wr, a, wd16);
  assign gbusStrb = mkStrb(tgt == TGT_GBUS, wr, gbusAddr, wd);
  assign pdataStrb = mkStrb(tgt == TGT_PDATA, wr, a, wd);
  assign pctrlStrb = mkStrb(tgt == TGT_PCTRL, wr, a, wd);
  // bridge fifos of 256 words sit behind these two strobes
  assign bregStrb = mkStrb(tgt == TGT_BREG, wr, a, wd);
  assign aperStrb = mkStrb(tgt == TGT_APER, wr, a, wd);

  ////////////////////////////////////////////////////////////////////////////
  // local registers: routing config and interrupt word
  logic [7:0] route_q;
  logic [15:0] iword_q;
  wire logic routeWr = (tgt == TGT_ROUTE) && cur.write;
  wire logic iwordWr = (tgt == TGT_IWORD) && cur.write;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      route_q <= ROUTE_RST;
      iword_q <= IWORD_RST;
    end else begin
      if (routeWr) route_q <= cur.wdata[ROUTE_W-1:0];
      if (iwordWr) iword_q <= cur.wdata[IWORD_W-1:0];
    end
  end

  assign linkRouting = route_q;
  assign interruptWord = iword_q;

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unassigned offsets and write-only registers read as zero
  logic [31:0] rdMux;

  always_comb begin
    rdMux = ZERO32;
    case (tgt)
      TGT_SRAM: rdMux = sramRdata;
      TGT_LINK: rdMux = linkInWord;
      TGT_CTST: rdMux = statusWord;
      TGT_ROUTE: rdMux = {24'h000000, route_q};
      TGT_IWORD: rdMux = {16'h0000, iword_q};
      TGT_SCAN: rdMux = {16'h0000, scanRdata};
      TGT_GBUS: rdMux = gbusRdata;
      TGT_PDATA: rdMux = {16'h0000, pdataRdata};
      TGT_PCTRL: rdMux = {16'h0000, pctrlRdata};
      TGT_BREG: rdMux = brgRdata;
      TGT_APER: rdMux = brgRdata;
      default: rdMux = ZERO32;
    endcase
  end

  // read data is registered; the valid pulse follows the granted read
  logic [31:0] rd_q;
  logic modRv_q, brgRv_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= ZERO32;
      modRv_q <= 1'b0;
      brgRv_q <= 1'b0;
    end else begin
      rd_q <= live ? rdMux : rd_q;
      modRv_q <= modGrant && modReq.req && !modReq.write;
      brgRv_q <= brgGrant && brgReq.req && !brgReq.write;
    end
  end

  assign rdData = rd_q;
  assign modRdValid = modRv_q;
  assign brgRdValid = brgRv_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_single_owner: assert property (@(posedge clk) disable iff (!nrst)
    !(modGrant && brgGrant)) else $error("both requesters granted");

  a_stall_no_drop: assert property (@(posedge clk) disable iff (!nrst)
    (modStall && !brgReq.req) |=> modGrant)
    else $error("module stalled without a competing owner");

  a_route_write: assert property (@(posedge clk) disable iff (!nrst)
    routeWr |=> linkRouting == $past(cur.wdata[7:0]))
    else $error("routing register did not take write");

  a_iword_write: assert property (@(posedge clk) disable iff (!nrst)
    iwordWr |=> interruptWord == $past(cur.wdata[15:0]))
    else $error("interrupt word did not take write");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
    (brgGrant && brgReq.req && brgReq.io && !brgReq.write &&
     brgReq.addr[7:0] == 8'h0C) |=> rdData == 32'h0000_0000)
    else $error("unmapped io offset read nonzero");

  a_ctrl_write_only: assert property (@(posedge clk) disable iff (!nrst)
    ctrlStrb.sel |-> (tgt == TGT_CTST && cur.write))
    else $error("control strobed on a read");

  sequence s_io_link_read;
    brgGrant && brgReq.req && brgReq.io && !brgReq.write &&
    brgReq.addr[7:0] == 8'h10;
  endsequence
  a_link_read: assert property (@(posedge clk) disable iff (!nrst)
    s_io_link_read |=> rdData == $past(linkInWord) && brgRdValid)
    else $error("link word read mismatch");

  a_dma_sram: assert property (@(posedge clk) disable iff (!nrst)
    (brgGrant && brgReq.req && brgReq.dma &&
     !brgReq.addr[DMA_ADDR_BIT + BYTE_LANE_W])
    |-> !sramStrb.sel)
    else $error("dma reached sram without line 28");

  a_mod_sram: assert property (@(posedge clk) disable iff (!nrst)
    (modGrant && modReq.req && modReq.addr[31:20] == 12'hD00)
    |-> sramStrb.sel)
    else $error("module sram window not decoded");

  a_alias_ctrl: assert property (@(posedge clk) disable iff (!nrst)
    (brgGrant && brgReq.req && !brgReq.io && !brgReq.dma &&
     brgReq.write && brgReq.addr == 32'h0020_0094) |-> ctrlStrb.sel)
    else $error("control alias not decoded");
endmodule

// ### testbench/cbd_resource_model.sv
// behavioural model of the resources that sit behind the decoder
`timescale 1ns/1ps
module cbd_resource_model
  import cbd_pkg::*;
#(
  parameter logic [31:0] SRAM_D = 32'h0000_0001,
  parameter logic [31:0] LINK_D = 32'h0000_0002,
  parameter logic [31:0] STAT_D = 32'h0000_0003,
  parameter logic [31:0] GBUS_D = 32'h0000_0004,
  parameter logic [31:0] BRG_D = 32'h0000_0005,
  parameter logic [15:0] SCAN_D = 16'h0006,
  parameter logic [15:0] PDAT_D = 16'h0007,
  parameter logic [15:0] PCTL_D = 16'h0008
)
(
  input wire cbd_strb_t sramStrb, // sram strobe
  input wire cbd_strb_t scanStrb, // scan controller strobe
  input wire cbd_strb_t gbusStrb, // global bus strobe
  input wire cbd_strb_t pdataStrb, // parallel data strobe
  input wire cbd_strb_t pctrlStrb, // parallel ctrl strobe
  input wire cbd_strb_t bregStrb, // bridge register strobe
  input wire cbd_strb_t aperStrb, // bridge aperture strobe
  output logic [31:0] sramRdata, // sram data
  output logic [31:0] linkInWord, // incoming link word
  output logic [31:0] statusWord, // status level
  output logic [15:0] scanRdata, // scan data
  output logic [31:0] gbusRdata, // global bus data
  output logic [15:0] pdataRdata, // parallel data
  output logic [15:0] pctrlRdata, // parallel status
  output logic [31:0] brgRdata // bridge data
);
  // answers with no wait states, the fastest strobe the module side allows;
  // a deselected source shows the inverse so stale data never matches
  assign sramRdata = sramStrb.sel ? SRAM_D : ~SRAM_D;
  assign scanRdata = scanStrb.sel ? SCAN_D : ~SCAN_D;
  assign gbusRdata = gbusStrb.sel ? GBUS_D : ~GBUS_D;
  assign pdataRdata = pdataStrb.sel ? PDAT_D : ~PDAT_D;
  assign pctrlRdata = pctrlStrb.sel ? PCTL_D : ~PCTL_D;
  assign brgRdata = (bregStrb.sel | aperStrb.sel) ? BRG_D : ~BRG_D;
  // link word and status are register levels, they stand at all times
  assign linkInWord = LINK_D;
  assign statusWord = STAT_D;
endmodule

// ### testbench/carrier_local_bus_decoder_tb_top.sv
// self-checking testbench for the carrier local bus decoder
`timescale 1ns/1ps
module carrier_local_bus_decoder_tb_top;
  import cbd_pkg::*;
  localparam logic [31:0] D_SRAM = 32'h5A5A_0001;
  localparam logic [31:0] D_LINK = 32'hC0DE_0010;
  localparam logic [31:0] D_STAT = 32'h5747_0014;
  localparam logic [31:0] D_GBUS = 32'h6B05_0000;
  localparam logic [31:0] D_BRG = 32'hB1D6_0000;
  localparam logic [15:0] D_SCAN = 16'h5CA1;
  localparam logic [15:0] D_PDAT = 16'hDA7A;
  localparam logic [15:0] D_PCTL = 16'hC7A1;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cbd_req_t modReq = '0;
  cbd_req_t brgReq = '0;
  logic modStall, modRdValid, brgStall, brgRdValid, modGrant, brgGrant;
  logic siteClockOut;
  logic [31:0] rdData, sramRdata, linkInWord, statusWord, gbusRdata;
  logic [31:0] brgRdata, rdm, rdb;
  logic [15:0] scanRdata, pdataRdata, pctrlRdata, interruptWord;
  logic [7:0] linkRouting;
  cbd_strb_t sramStrb, linkStrb, ctrlStrb, intSetupStrb, scanStrb;
  cbd_strb_t gbusStrb, pdataStrb, pctrlStrb, bregStrb, aperStrb;
  logic [31:0] unmapped [6] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h1C,
    32'h24};
  int num_errors = 0;
  int n_checks = 0;

  cbd_local_bus_decoder i_cbd_local_bus_decoder (.clk, .nrst, .modReq,
    .modStall, .modRdValid, .brgReq, .brgStall, .brgRdValid, .rdData,
    .modGrant, .brgGrant, .siteClockOut, .sramStrb, .sramRdata, .linkStrb,
    .linkInWord, .ctrlStrb, .statusWord, .intSetupStrb, .linkRouting,
    .interruptWord, .scanStrb, .scanRdata, .gbusStrb, .gbusRdata,
    .pdataStrb, .pctrlStrb, .pdataRdata, .pctrlRdata, .bregStrb, .aperStrb,
    .brgRdata);
  cbd_resource_model #(.SRAM_D(D_SRAM), .LINK_D(D_LINK), .STAT_D(D_STAT),
    .GBUS_D(D_GBUS), .BRG_D(D_BRG), .SCAN_D(D_SCAN), .PDAT_D(D_PDAT),
    .PCTL_D(D_PCTL)) i_cbd_resource_model (.sramStrb, .scanStrb, .gbusStrb,
    .pdataStrb, .pctrlStrb, .bregStrb, .aperStrb, .sramRdata, .linkInWord,
    .statusWord, .scanRdata, .gbusRdata, .pdataRdata, .pctrlRdata,
    .brgRdata);

  ////////////////////////////////////////////////////////////////////////////
  // clock and per-cycle checks
  always #25 clk = ~clk;
  // sampled a little after the edge so the copied clock has settled
  always @(posedge clk) begin
    #5;
    chk(siteClockOut, 1'b1);
    if (nrst === 1'b1) chk(modGrant & brgGrant, 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict and watchdog
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #500us;
    num_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus access tasks
  // strobe select of one target; no target means no strobe at all
  function automatic logic selOf(cbd_tgt_t t);
    case (t)
      TGT_SRAM: return sramStrb.sel;
      TGT_LINK: return linkStrb.sel;
      TGT_CTST: return ctrlStrb.sel;
      TGT_INTS: return intSetupStrb.sel;
      TGT_SCAN: return scanStrb.sel;
      TGT_GBUS: return gbusStrb.sel;
      TGT_PDATA: return pdataStrb.sel;
      TGT_PCTRL: return pctrlStrb.sel;
      TGT_BREG: return bregStrb.sel;
      TGT_APER: return aperStrb.sel;
      default: return sramStrb.sel | linkStrb.sel | ctrlStrb.sel |
        intSetupStrb.sel | scanStrb.sel | gbusStrb.sel | pdataStrb.sel |
        pctrlStrb.sel | bregStrb.sel | aperStrb.sel;
    endcase
  endfunction

  // one access: raise, wait for grant, hold one granted cycle, then drop
  task automatic acc(input logic m, w, io, d, input logic [31:0] a, wd,
    input cbd_tgt_t tg, output logic [31:0] rd);
    cbd_req_t r;
    int n;
    r = '{req: 1'b1, write: w, io: io, dma: d, addr: a, wdata: wd};
    n = 0;
    @(posedge clk);
    #1;
    if (m) modReq = r;
    else brgReq = r;
    while ((m ? modGrant : brgGrant) !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 50, 1'b1);
    // local registers raise no outside strobe
    if (w) chk(selOf(tg), !(tg inside {TGT_NONE, TGT_ROUTE,
      TGT_IWORD}));
    if (w && tg == TGT_GBUS) chk({gbusStrb.addr[30], gbusStrb.addr[19]},
      2'b11);
    @(posedge clk);
    #1;
    chk(m ? modRdValid : brgRdValid, !w);
    rd = rdData;
    r.req = 1'b0;
    if (m) modReq = r;
    else brgReq = r;
  endtask

  // write, then read back the same place and compare the read
  task automatic tst(input logic m, io, d, input logic [31:0] a, wd,
    input cbd_tgt_t tg, input logic [31:0] ex);
    logic [31:0] r;
    acc(m, 1'b1, io, d, a, wd, tg, r);
    acc(m, 1'b0, io, d, a, wd, tg, r);
    chk(r, ex);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    chk(linkRouting, 8'h2C);
    chk(interruptWord, 16'h0000);
    chk(modGrant | brgGrant, 1'b0);
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    // host io window
    tst(0, 1, 0, 32'h10, 32'h1111_2222, TGT_LINK, D_LINK);
    tst(0, 1, 0, 32'h14, 32'h0000_001F, TGT_CTST, D_STAT);
    tst(0, 1, 0, 32'h18, 32'h0000_0700, TGT_INTS, 32'h0);
    tst(0, 1, 0, 32'h20, 32'h0000_00AB, TGT_ROUTE, 32'hAB);
    chk(linkRouting, 8'hAB);
    tst(0, 1, 0, 32'h3F, 32'h0000_0051, TGT_ROUTE, 32'h51);
    tst(0, 1, 0, 32'h40, 32'h1234_BEEF, TGT_IWORD, 32'hBEEF);
    chk(interruptWord, 16'hBEEF);
    tst(0, 1, 0, 32'h80, 32'h0000_0123, TGT_SCAN, {16'h0, D_SCAN});
    tst(0, 1, 0, 32'hAF, 32'h0000_0456, TGT_SCAN, {16'h0, D_SCAN});
    // unassigned offsets: no strobe, read zero, routing untouched
    foreach (unmapped[i]) begin
      tst(0, 1, 0, unmapped[i], 32'hFFFF_FFFF, TGT_NONE, 32'h0);
    end
    chk(linkRouting, 8'h51);
    // host memory window
    tst(0, 0, 0, 32'h0000_0000, 32'h1, TGT_SRAM, D_SRAM);
    tst(0, 0, 0, 32'h000F_FFFC, 32'h2, TGT_SRAM, D_SRAM);
    tst(0, 0, 0, 32'h0020_0090, 32'h3, TGT_LINK, D_LINK);
    tst(0, 0, 0, 32'h0020_0094, 32'h4, TGT_CTST, D_STAT);
    tst(0, 0, 0, 32'h0020_0098, 32'h5, TGT_INTS, 32'h0);
    tst(0, 0, 0, 32'h0020_0000, 32'h6, TGT_GBUS, D_GBUS);
    tst(0, 0, 0, 32'h0020_007C, 32'h7, TGT_GBUS, D_GBUS);
    tst(0, 0, 0, 32'h0020_0240, 32'h8, TGT_PDATA, {16'h0, D_PDAT});
    tst(0, 0, 0, 32'h0020_025C, 32'h9, TGT_PDATA, {16'h0, D_PDAT});
    tst(0, 0, 0, 32'h0020_0260, 32'hA, TGT_PCTRL, {16'h0, D_PCTL});
    tst(0, 0, 0, 32'h0020_027C, 32'hB, TGT_PCTRL, {16'h0, D_PCTL});
    tst(0, 0, 1, 32'h4000_0000, 32'hC, TGT_SRAM, D_SRAM);
    tst(0, 0, 1, 32'h400F_FFFC, 32'hD, TGT_SRAM, D_SRAM);
    // master module window
    tst(1, 0, 0, 32'hD000_0000, 32'hE, TGT_SRAM, D_SRAM);
    tst(1, 0, 0, 32'hD00F_FFFC, 32'hF, TGT_SRAM, D_SRAM);
    tst(1, 0, 0, 32'h1C00_0000, 32'h10, TGT_BREG, D_BRG);
    tst(1, 0, 0, 32'h1C00_00FC, 32'h11, TGT_BREG, D_BRG);
    tst(1, 0, 0, 32'h1800_0000, 32'h12, TGT_APER, D_BRG);
    tst(1, 0, 0, 32'h183F_FFFC, 32'h13, TGT_APER, D_BRG);
    // both ask together: bridge wins, module waits and still completes
    fork
      acc(1, 0, 0, 0, 32'hD000_0010, 32'h0, TGT_SRAM, rdm);
      acc(0, 0, 0, 0, 32'h0020_0094, 32'h0, TGT_CTST, rdb);
      begin
        @(posedge clk);
        #1;
        @(posedge clk);
        #2;
        chk(brgGrant, 1'b1);
        chk(modStall, 1'b1);
      end
    join
    chk(rdb, D_STAT);
    chk(rdm, D_SRAM);
    end_sim();
  end
endmodule
